// ### core/dao_offset_ctrl.sv
// command level control of the address offset mode
`timescale 1ns/1ps
// Operation
// - enable subcommand remaps block zero to protected area
// - disable, hard reset, power-on reset clear mode
// - soft reset clears mode when revert enabled
// - capacity reported equals former protected area
// - remapped addresses wrap modulo drive size
// - no protected area aborts enable, mode stays off
// - disable restores nonvolatile max capacity
// - identify word 83 bit 7 set
// - identify word 86 bit 7 tracks mode
// - ranges crossing native max rejected in mode
// - no read look-ahead while mode active
// - entering mode moves max pointer to reserved end
// - native max read returns true top block
module dao_offset_ctrl
	import dao_pkg::*;
(
	// clock and resets
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic hardReset,
	input wire logic softReset,
	// command issue
	input wire logic cmdValid,
	input wire logic [7:0] cmdCode,
	input wire logic [7:0] cmdFeature,
	input wire logic [LBA_W-1:0] cmdLba,
	// drive geometry
	input wire logic [LBA_W-1:0] nativeMaxLba,
	input wire logic [LBA_W-1:0] nvMaxLba,
	input wire logic nvAreaValid,
	// media access check
	input wire logic [LBA_W-1:0] accLba,
	input wire logic [LBA_W-1:0] accCount,
	input wire logic lookAheadEn,
	// command completion
	output logic cmdDone,
	output logic cmdAbort,
	output logic [LBA_W-1:0] cmdResult,
	// access result
	output logic [LBA_W-1:0] physLba,
	output logic accReject,
	output logic lookAheadGo,
	// identify and capacity
	output logic offsetActive,
	output logic [LBA_W-1:0] maxLba,
	output logic [LBA_W-1:0] idCapacity,
	output logic [15:0] idWord83,
	output logic [15:0] idWord86
);
	typedef struct packed {
		dao_state_e state;
		logic offsetOn;
		logic revertOn;
		logic [LBA_W-1:0] maxPtr;
		logic [LBA_W-1:0] capacity;
		logic [7:0] code;
		logic [7:0] feat;
		logic [LBA_W-1:0] lba;
		logic done;
		logic abort;
		logic [LBA_W-1:0] result;
		logic [LBA_W-1:0] phys;
		logic reject;
		logic lookGo;
		logic [15:0] w83;
		logic [15:0] w86;
	} dao_regs_s;

	dao_regs_s r_q;
	dao_regs_s r_d;
	logic [LBA_W-1:0] mapLba;
	logic crossing;

	// ----------------------------------------------------------------
	// address remap
	// ----------------------------------------------------------------
	dao_range_check uRange (
		.offsetOn(r_q.offsetOn),
		.nvMaxLba(nvMaxLba),
		.nativeMaxLba(nativeMaxLba),
		.hostLba(accLba),
		.hostCount(accCount),
		.physLba(mapLba),
		.crossesNative(crossing)
	);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		r_d = r_q;
		r_d.done = 1'b0;
		r_d.abort = 1'b0;
		r_d.phys = mapLba;
		r_d.reject = crossing;
		r_d.lookGo = lookAheadEn && !r_q.offsetOn;
		r_d.w83 = 16'h0000;
		r_d.w83[ID_SUPPORT_BIT] = 1'b1;
		r_d.w86 = 16'h0000;
		r_d.w86[ID_ACTIVE_BIT] = r_q.offsetOn;
		unique case (r_q.state)
			DAO_IDLE: begin
				if (cmdValid) begin
					r_d.code = cmdCode;
					r_d.feat = cmdFeature;
					r_d.lba = cmdLba;
					r_d.state = DAO_EXEC;
				end
			end
			DAO_EXEC: begin
				r_d.state = DAO_DONE;
				r_d.done = 1'b1;
				r_d.result = '0;
				if (r_q.code == CMD_READ_NATIVE_MAX) begin
					r_d.result = nativeMaxLba;
				end else if (r_q.code == CMD_SET_MAX) begin
					// lifting protection leaves the native check alive
					r_d.maxPtr = (r_q.lba > nativeMaxLba) ?
						nativeMaxLba : r_q.lba;
					if (!r_q.offsetOn) begin
						r_d.capacity = r_d.maxPtr;
					end
				end else if (r_q.code == CMD_SET_FEATURES) begin
					if (r_q.feat == SUB_OFFSET_ON) begin
						if (!nvAreaValid) begin
							r_d.abort = 1'b1;
						end else begin
							r_d.offsetOn = 1'b1;
							// former reserved area size, as last block
							r_d.capacity = LBA_W'(nativeMaxLba - nvMaxLba
								- 28'h0000001);
							r_d.maxPtr = r_d.capacity;
						end
					end else if (r_q.feat == SUB_OFFSET_OFF) begin
						r_d.offsetOn = 1'b0;
						r_d.capacity = nvMaxLba;
						r_d.maxPtr = nvMaxLba;
					end else if (r_q.feat == SUB_REVERT_ON) begin
						r_d.revertOn = 1'b1;
					end else if (r_q.feat == SUB_REVERT_OFF) begin
						r_d.revertOn = 1'b0;
					end
				end
			end
			DAO_DONE: begin
				r_d.state = DAO_IDLE;
			end
		endcase
		if (softReset) begin
			r_d.state = DAO_IDLE;
			if (r_q.revertOn) begin
				r_d.offsetOn = 1'b0;
				r_d.capacity = nvMaxLba;
				r_d.maxPtr = nvMaxLba;
			end
		end
		if (hardReset) begin
			r_d.state = DAO_IDLE;
			r_d.offsetOn = 1'b0;
			r_d.revertOn = RST_REVERT_ON;
			r_d.capacity = nvMaxLba;
			r_d.maxPtr = nvMaxLba;
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			r_q <= '0;
			r_q.state <= DAO_IDLE;
			r_q.offsetOn <= RST_OFFSET_ON;
			r_q.revertOn <= RST_REVERT_ON;
			r_q.maxPtr <= RST_LBA;
			r_q.capacity <= RST_LBA;
		end else begin
			r_q <= r_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign cmdDone = r_q.done;
	assign cmdAbort = r_q.abort;
	assign cmdResult = r_q.result;
	assign physLba = r_q.phys;
	assign accReject = r_q.reject;
	assign lookAheadGo = r_q.lookGo;
	assign offsetActive = r_q.offsetOn;
	assign maxLba = r_q.maxPtr;
	assign idCapacity = r_q.capacity;
	assign idWord83 = r_q.w83;
	assign idWord86 = r_q.w86;
endmodule

// ### core/dao_range_check.sv
// offset remap and native boundary check for one access
`timescale 1ns/1ps
module dao_range_check
	import dao_pkg::*;
(
	// mode and geometry
	input wire logic offsetOn,
	input wire logic [LBA_W-1:0] nvMaxLba,
	input wire logic [LBA_W-1:0] nativeMaxLba,
	// access
	input wire logic [LBA_W-1:0] hostLba,
	input wire logic [LBA_W-1:0] hostCount,
	// result
	output logic [LBA_W-1:0] physLba,
	output logic crossesNative
);
	logic [LBA_W:0] sum;
	logic [LBA_W:0] lastLba;
	logic [LBA_W:0] drive;
	always_comb begin
		drive = {1'b0, nativeMaxLba} + {{LBA_W{1'b0}}, 1'b1};
		// remap base is first block of the protected area
		sum = {1'b0, hostLba} + {1'b0, nvMaxLba} + {{LBA_W{1'b0}}, 1'b1};
		physLba = hostLba;
		if (offsetOn) begin
			if (sum >= drive) begin
				physLba = LBA_W'(sum - drive);
			end else begin
				physLba = sum[LBA_W-1:0];
			end
		end
		lastLba = {1'b0, physLba} + {1'b0, hostCount} - {{LBA_W{1'b0}}, 1'b1};
		// in offset mode only, a range that passes native max, wrapped or not, is refused
		crossesNative = offsetOn && (hostCount != '0)
			&& (lastLba > {1'b0, nativeMaxLba});
	end
endmodule

// ### pkg/dao_pkg.sv
// constants and types for the disk address offset mode block
package dao_pkg;
	localparam int LBA_W = 28;
	localparam logic [7:0] CMD_SET_FEATURES = 8'hef;
	localparam logic [7:0] CMD_READ_NATIVE_MAX = 8'hf8;
	localparam logic [7:0] CMD_SET_MAX = 8'hf9;
	localparam logic [7:0] SUB_OFFSET_ON = 8'h09;
	localparam logic [7:0] SUB_OFFSET_OFF = 8'h89;
	localparam logic [7:0] SUB_REVERT_ON = 8'hcc;
	localparam logic [7:0] SUB_REVERT_OFF = 8'h66;
	localparam int ID_SUPPORT_BIT = 7;
	localparam int ID_ACTIVE_BIT = 7;
	localparam logic RST_OFFSET_ON = 1'b0;
	localparam logic RST_REVERT_ON = 1'b0;
	localparam logic [LBA_W-1:0] RST_LBA = 28'h0000000;
	localparam logic [1:0] CMD_LATENCY = 2'h1;
	typedef enum logic [2:0] {
		DAO_IDLE = 3'b001,
		DAO_EXEC = 3'b010,
		DAO_DONE = 3'b100
	} dao_state_e;
endpackage

// ### testbench/dao_host_model.sv
// host issuing drive commands
`timescale 1ns/1ps
module dao_host_model
	import dao_pkg::*;
(
	input wire logic clk_sys,
	input wire logic cmdDone,
	input wire logic cmdAbort,
	output logic cmdValid,
	output logic [7:0] cmdCode,
	output logic [7:0] cmdFeature,
	output logic [LBA_W-1:0] cmdLba
);
	logic done;
	logic abort;
	initial {cmdValid, cmdCode, cmdFeature, cmdLba} = '0;
	task automatic issue(input logic [7:0] c, f, input logic [LBA_W-1:0] a);
		@(negedge clk_sys);
		{cmdValid, cmdCode, cmdFeature, cmdLba} = {1'b1, c, f, a};
		@(negedge clk_sys);
		// released lines show no stale value
		{cmdValid, cmdCode, cmdFeature, cmdLba} = {1'b0, ~c, ~f, ~a};
		@(negedge clk_sys);
		done = cmdDone;
		abort = cmdAbort;
	endtask
	task automatic reach_all(input logic [LBA_W-1:0] top);
		issue(CMD_SET_MAX, 8'h00, top);
	endtask
endmodule

// ### testbench/dao_offset_ctrl_assertions.sv
// offset control checker
`timescale 1ns/1ps
module dao_offset_ctrl_assertions
	import dao_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic cmdValid,
	input wire logic [7:0] cmdCode,
	input wire logic [7:0] cmdFeature,
	input wire logic nvAreaValid,
	input wire logic cmdDone,
	input wire logic cmdAbort,
	input wire logic lookAheadGo,
	input wire logic accReject,
	input wire logic offsetActive,
	input wire logic [15:0] idWord83,
	input wire logic [15:0] idWord86
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence sSf(f);
		cmdValid && cmdCode == CMD_SET_FEATURES && cmdFeature == f;
	endsequence
	AST_ON: assert property (sSf(SUB_OFFSET_ON) ##0 nvAreaValid
		|-> ##2 offsetActive && !cmdAbort) else $error("no entry");
	AST_NOAR: assert property (sSf(SUB_OFFSET_ON) ##0 !nvAreaValid
		##0 !offsetActive |-> ##2 cmdAbort && !offsetActive)
		else $error("no abort");
	AST_ABORT: assert property (cmdAbort |-> cmdDone)
		else $error("abort without done");
	AST_OFF: assert property (sSf(SUB_OFFSET_OFF) |-> ##2 !offsetActive)
		else $error("still in mode");
	AST_W83: assert property (!$past(rst) |-> idWord83[7])
		else $error("support bit low");
	AST_W86: assert property (!$past(rst)
		|-> idWord86[7] == $past(offsetActive)) else $error("flag lags");
	AST_LA: assert property (offsetActive |=> !lookAheadGo)
		else $error("look-ahead in mode");
	AST_REJ: assert property (!offsetActive |=> !accReject)
		else $error("reject out of mode");
endmodule

bind dao_offset_ctrl dao_offset_ctrl_assertions u_chk (.clk_sys, .rst,
	.cmdValid, .cmdCode, .cmdFeature, .nvAreaValid, .cmdDone, .cmdAbort,
	.lookAheadGo, .accReject, .offsetActive, .idWord83, .idWord86);

// ### testbench/testbench.sv
// offset control bench
`timescale 1ns/1ps
module testbench
	import dao_pkg::*;
();
	logic clk_sys, rst, hardReset, softReset, cmdValid, nvAreaValid;
	logic lookAheadEn, cmdDone, cmdAbort, accReject, lookAheadGo;
	logic offsetActive;
	logic [7:0] cmdCode, cmdFeature;
	logic [LBA_W-1:0] cmdLba, accLba, accCount, cmdResult, physLba;
	logic [LBA_W-1:0] maxLba, idCapacity;
	logic [15:0] idWord83, idWord86;
	int failCount = 0;
	int testsRun = 0;
	int cycles = 0;
	localparam logic [LBA_W-1:0] NAT = 28'h00fffff;
	localparam logic [LBA_W-1:0] NV = 28'h00fbfff;
	localparam logic [LBA_W-1:0] TOP = NAT - NV - 28'h1;
	dao_offset_ctrl DUT (.clk_sys, .rst, .hardReset, .softReset, .cmdValid,
		.cmdCode, .cmdFeature, .cmdLba, .nativeMaxLba(NAT), .nvMaxLba(NV),
		.nvAreaValid, .accLba, .accCount, .lookAheadEn, .cmdDone, .cmdAbort,
		.cmdResult, .physLba, .accReject, .lookAheadGo, .offsetActive,
		.maxLba, .idCapacity, .idWord83, .idWord86);
	dao_host_model host (.clk_sys, .cmdDone, .cmdAbort, .cmdValid,
		.cmdCode, .cmdFeature, .cmdLba);
	always #2.5 clk_sys = ~clk_sys;
	task automatic chk(input logic [LBA_W-1:0] got, exp, input string m);
		testsRun++;
		if (got !== exp) begin
			failCount++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask
	task automatic tallyAndFinish;
		if (failCount == 0 && testsRun > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic acc(input logic [LBA_W-1:0] a, n);
		@(negedge clk_sys);
		{accLba, accCount} = {a, n};
		@(negedge clk_sys);
	endtask
	task automatic kick(ref logic s);
		s = 1'b1;
		@(negedge clk_sys);
		s = 1'b0;
		@(negedge clk_sys);
	endtask
	task automatic t_abort;
		nvAreaValid = 1'b0;
		host.issue(CMD_SET_FEATURES, SUB_OFFSET_ON, '0);
		chk({host.done, host.abort, offsetActive}, 3'b110, "abort");
		nvAreaValid = 1'b1;
	endtask
	task automatic t_enable;
		host.issue(CMD_SET_FEATURES, SUB_OFFSET_ON, '0);
		chk({host.done, host.abort}, 2'b10, "enable");
		chk(idCapacity, TOP, "cap on");
		chk(maxLba, TOP, "max on");
		acc('0, 28'h1);
		chk(physLba, NV + 28'h1, "block zero");
		chk({idWord86[7], lookAheadGo}, 2'b10, "flag, look-ahead");
		acc(TOP + 28'h1, 28'h1);
		chk(physLba, '0, "wrap");
		host.reach_all(NAT);
		host.issue(CMD_READ_NATIVE_MAX, 8'h00, '0);
		chk(cmdResult, NAT, "native");
		acc(TOP, 28'h2);
		chk(accReject, 1'b1, "cross");
		acc(TOP, 28'h1);
		chk(accReject, 1'b0, "edge");
	endtask
	task automatic t_disable;
		host.issue(CMD_SET_FEATURES, SUB_OFFSET_OFF, '0);
		chk(idCapacity, NV, "cap off");
		acc(28'h5, 28'h1);
		chk(physLba, 28'h5, "unmapped");
		chk({offsetActive, idWord86[7], lookAheadGo}, 3'b001, "off");
	endtask
	task automatic t_resets;
		host.issue(CMD_SET_FEATURES, SUB_OFFSET_ON, '0);
		kick(softReset);
		chk(offsetActive, 1'b1, "soft kept");
		host.issue(CMD_SET_FEATURES, SUB_REVERT_ON, '0);
		kick(softReset);
		chk(offsetActive, 1'b0, "soft cleared");
		host.issue(CMD_SET_FEATURES, SUB_OFFSET_ON, '0);
		kick(hardReset);
		chk(offsetActive, 1'b0, "hard cleared");
	endtask
	initial begin
		{clk_sys, rst, hardReset, softReset, lookAheadEn} = 5'b01001;
		{nvAreaValid, accLba, accCount} = {1'b1, 56'h0};
		repeat (16) @(negedge clk_sys);
		rst = 1'b0;
		@(negedge clk_sys);
		chk({idWord83[7], idWord86[7]}, 2'b10, "identify");
		t_abort();
		t_enable();
		t_disable();
		t_resets();
		tallyAndFinish();
	end
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 2000) begin
			failCount++;
			tallyAndFinish();
		end
	end
endmodule
